// ### hdl/odc_pkg.sv
// package: register map, field layout and reset values of the on-chip debug control block
package odc_pkg;
  // word indices; byte address is four times the index
  localparam logic [29:0] LINK_CTRL_IDX = 30'h0ffe086;
  localparam logic [29:0] CPU_CTRL_IDX  = 30'h0ffe088;
  localparam logic [29:0] EV_STAT_IDX   = 30'h0ffe089;
  localparam logic [29:0] EV_EN_IDX     = 30'h0ffe08a;
  localparam logic [29:0] EV_CLR_IDX    = 30'h0ffe08b;
  localparam logic [29:0] RUN_STAT_IDX  = 30'h0ffe08c;

  typedef enum logic [2:0] {
    ODC_RN_LINK = 3'h0, ODC_RN_CPU = 3'h1, ODC_RN_EVST = 3'h2,
    ODC_RN_EVEN = 3'h3, ODC_RN_EVCL = 3'h4, ODC_RN_DSTAT = 3'h5
  } odc_reg_num_t;

  localparam int LC_LOCK   = 7;
  localparam int LC_DBGEN  = 6;
  localparam int LC_CRC    = 3;
  localparam int LC_UART   = 2;
  localparam int LC_CHSEL  = 1;
  localparam int LC_SEARCH = 0;
  localparam logic [7:0] LINK_CTRL_RST   = 8'hc9;
  localparam logic [7:0] LINK_CTRL_WMASK = 8'hcf;

  localparam int CC_HALT    = 7;
  localparam int CC_BPHALT  = 6;
  localparam int CC_BPEN    = 5;
  localparam int CC_STOPCLK = 4;
  localparam int CC_STEP    = 0;
  localparam logic [7:0] CPU_CTRL_RST   = 8'h00;
  localparam logic [7:0] CPU_CTRL_WMASK = 8'hf1;

  localparam logic [7:0] AB_CHAR_ZERO = 8'h80;
  localparam logic [7:0] AB_CHAR_ONE  = 8'h0d;

  localparam int EV_W        = 4;
  localparam int EV_BREAK    = 0;
  localparam int EV_TRAP     = 1;
  localparam int EV_AUTOBAUD = 2;
  localparam int EV_SERR     = 3;

  localparam int DS_HALT  = 7;
  localparam int DS_BREAK = 6;
  localparam int DS_STOP  = 4;
  localparam int DS_STEP  = 0;

  typedef enum logic [2:0] {
    ODC_STEP_IDLE  = 3'b001,
    ODC_STEP_GRANT = 3'b010,
    ODC_STEP_WAIT  = 3'b100
  } odc_step_t;
endpackage

// ### hdl/odc_reg_if.sv
// interface: decoded register access between the bus slave and the control core
`timescale 1ns/10ps
interface odc_reg_if;
  import odc_pkg::*;
  logic         hit;
  logic         wr;
  odc_reg_num_t reg_num;
  logic [7:0]   wdata;
  logic [7:0]   rdata;
  modport slave (output hit, wr, reg_num, wdata, input rdata);
  modport core  (input hit, wr, reg_num, wdata, output rdata);
endinterface

// ### hdl/odc_wb_slave.sv
// module: classic wishbone slave with one-wait-state ack for the debug registers
`timescale 1ns/10ps
module odc_wb_slave
  import odc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  odc_reg_if.slave         regs
);
  logic req;
  assign req = wb_cyc_i & wb_stb_i;

  always_comb begin
    regs.hit     = 1'b1;
    regs.reg_num = ODC_RN_LINK;
    unique case (wb_adr_i[31:2])
      LINK_CTRL_IDX: regs.reg_num = ODC_RN_LINK;
      CPU_CTRL_IDX:  regs.reg_num = ODC_RN_CPU;
      EV_STAT_IDX:   regs.reg_num = ODC_RN_EVST;
      EV_EN_IDX:     regs.reg_num = ODC_RN_EVEN;
      EV_CLR_IDX:    regs.reg_num = ODC_RN_EVCL;
      RUN_STAT_IDX:  regs.reg_num = ODC_RN_DSTAT;
      default:       regs.hit = 1'b0;
    endcase
  end

  // writes land on the edge where the master sees ack; unmapped ones ack and vanish
  assign regs.wr    = req & wb_we_i & wb_ack_o & wb_sel_i[0] & regs.hit;
  assign regs.wdata = wb_dat_i[7:0];

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req & ~wb_ack_o) begin
      wb_dat_o <= {24'h00_0000, (regs.hit & ~wb_we_i) ? regs.rdata : 8'h00};
    end
  end

  a_ack_one_cycle: assert property (@(posedge core_clk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
endmodule // odc_wb_slave

// ### hdl/odc_event_irq.sv
// module: sticky event status, enable mask and level interrupt
`timescale 1ns/10ps
module odc_event_irq #(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] ev_set,
  input  wire logic         clr_wr,
  input  wire logic         en_wr,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] status,
  output logic      [W-1:0] enable,
  output logic              irq
);
  if (W < 1 || W > 8) begin : g_bad_w
    $error("event width must be 1..8");
  end

  // a new event beats a clear landing in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      status <= '0;
    end else begin
      status <= (status & ~(clr_wr ? wdata : '0)) | ev_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      enable <= '0;
    end else if (en_wr) begin
      enable <= wdata;
    end
  end

  assign irq = |(status & enable);

  a_set_beats_clr: assert property (@(posedge core_clk) disable iff (!rstn)
    |ev_set |=> |status) else $error("event lost against clear");
endmodule // odc_event_irq

// ### hdl/odc_top.sv
// module: on-chip debug control core with link and cpu debug control registers
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/10ps
module odc_top
  import odc_pkg::*;
#(
  parameter int BAUD_W = 16
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              debug_uart_option,
  input  wire logic              rx_byte_valid,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              rx_serial_error,
  input  wire logic              autobaud_done,
  input  wire logic [BAUD_W-1:0] autobaud_count,
  input  wire logic              break_instr_exec,
  input  wire logic              hw_breakpoint_hit,
  input  wire logic              cpu_in_stop,
  input  wire logic              instr_retired,
  output logic                   debug_mode_enable,
  output logic                   command_crc_enable,
  output logic                   serial_port_on,
  output logic                   autobaud_char_select,
  output logic      [7:0]        autobaud_char,
  output logic                   autobaud_search,
  output logic      [BAUD_W-1:0] baud_reload,
  output logic                   cmd_byte_valid,
  output logic                   uart_byte_valid,
  output logic      [7:0]        rx_data,
  output logic                   cpu_fetch_stall,
  output logic                   cpu_step_grant,
  output logic                   cpu_loop_on_break,
  output logic                   breakpoint_event,
  output logic                   illegal_trap,
  output logic                   stop_mode_clock_gate,
  output logic                   break_reached_flag,
  output logic                   irq
);
  if (BAUD_W < 8 || BAUD_W > 32) begin : g_bad_baud
    $error("BAUD_W must be 8..32");
  end

  odc_reg_if regs ();

  odc_wb_slave u_wb (
    .core_clk (core_clk),
    .rstn     (rstn),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_sel_i (wb_sel_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .regs     (regs.slave)
  );

  logic [7:0]      link_ctrl;
  logic [7:0]      cpu_ctrl;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_status;
  logic [EV_W-1:0] ev_enable;
  logic            wr_link;
  logic            wr_cpu;
  logic [7:0]      next_link_ctrl;
  logic            bp_any;
  logic            bp_taken;
  logic            halt_written_zero;
  odc_step_t       step_state;

  assign wr_link = regs.wr & (regs.reg_num == ODC_RN_LINK);
  assign wr_cpu  = regs.wr & (regs.reg_num == ODC_RN_CPU);

  // ---------------- debug link control ----------------
  // one merge per bit keeps blocked fields at their old value while the rest still load
  always_comb begin
    next_link_ctrl = link_ctrl;
    if (wr_link && !link_ctrl[LC_LOCK]) begin
      next_link_ctrl[LC_LOCK]  = regs.wdata[LC_LOCK];
      next_link_ctrl[LC_DBGEN] = regs.wdata[LC_DBGEN];
      next_link_ctrl[LC_CRC]   = regs.wdata[LC_CRC];
      next_link_ctrl[LC_UART]  = regs.wdata[LC_UART];
      if (!link_ctrl[LC_DBGEN]) begin
        next_link_ctrl[LC_CHSEL]  = regs.wdata[LC_CHSEL];
        next_link_ctrl[LC_SEARCH] = regs.wdata[LC_SEARCH];
      end
    end
    // a finished measurement ends the search
    if (link_ctrl[LC_SEARCH] && autobaud_done) begin
      next_link_ctrl[LC_SEARCH] = 1'b0;
    end
    // an error while debugging restarts the search, and wins over the self clear
    if (link_ctrl[LC_DBGEN] && rx_serial_error) begin
      next_link_ctrl[LC_SEARCH] = 1'b1;
    end
    if (debug_uart_option) begin
      next_link_ctrl[LC_LOCK] = 1'b1;
    end
    next_link_ctrl = next_link_ctrl & LINK_CTRL_WMASK;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      link_ctrl <= LINK_CTRL_RST;
    end else begin
      link_ctrl <= next_link_ctrl;
    end
  end

  assign debug_mode_enable    = link_ctrl[LC_DBGEN];
  assign command_crc_enable   = link_ctrl[LC_DBGEN] & link_ctrl[LC_CRC];
  assign serial_port_on       = link_ctrl[LC_UART] & ~link_ctrl[LC_DBGEN];
  assign autobaud_char_select = link_ctrl[LC_CHSEL];
  assign autobaud_search      = link_ctrl[LC_SEARCH];
  assign autobaud_char        = link_ctrl[LC_CHSEL] ? AB_CHAR_ONE : AB_CHAR_ZERO;

  // the measured count only loads while a search is armed
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      baud_reload <= '0;
    end else if (link_ctrl[LC_SEARCH] && autobaud_done) begin
      baud_reload <= autobaud_count;
    end
  end

  // received bytes go to at most one consumer (none with debug and serial port both off); the mode is sampled per byte
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cmd_byte_valid  <= 1'b0;
      uart_byte_valid <= 1'b0;
      rx_data         <= 8'h00;
    end else begin
      cmd_byte_valid  <= rx_byte_valid & link_ctrl[LC_DBGEN];
      uart_byte_valid <= rx_byte_valid & ~link_ctrl[LC_DBGEN] & link_ctrl[LC_UART];
      if (rx_byte_valid) begin
        rx_data <= rx_byte;
      end
    end
  end

  // ---------------- cpu debug control ----------------
  assign bp_any   = break_instr_exec | hw_breakpoint_hit;
  assign bp_taken = bp_any & cpu_ctrl[CC_BPEN];
  assign halt_written_zero = wr_cpu & ~regs.wdata[CC_HALT];

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cpu_ctrl[7:1] <= CPU_CTRL_RST[7:1];
    end else begin
      if (wr_cpu) begin
        // reserved bits are masked off whatever software writes
        cpu_ctrl[7:1] <= regs.wdata[7:1] & CPU_CTRL_WMASK[7:1];
      end
      if (bp_taken && cpu_ctrl[CC_BPHALT]) begin
        cpu_ctrl[CC_HALT] <= 1'b1;
      end
    end
  end

  // step bit: armed by a write while halted, dropped once the instruction retires
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cpu_ctrl[CC_STEP] <= CPU_CTRL_RST[CC_STEP];
    end else if (step_state == ODC_STEP_WAIT && instr_retired) begin
      cpu_ctrl[CC_STEP] <= 1'b0;
    end else if (wr_cpu && regs.wdata[CC_STEP] && cpu_ctrl[CC_HALT]) begin
      cpu_ctrl[CC_STEP] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      step_state <= ODC_STEP_IDLE;
    end else begin
      unique case (step_state)
        ODC_STEP_IDLE: begin
          if (cpu_ctrl[CC_STEP] && cpu_ctrl[CC_HALT]) begin
            step_state <= ODC_STEP_GRANT;
          end
        end
        ODC_STEP_GRANT: begin
          step_state <= ODC_STEP_WAIT;
        end
        ODC_STEP_WAIT: begin
          if (instr_retired) begin
            step_state <= ODC_STEP_IDLE;
          end
        end
        default: step_state <= ODC_STEP_IDLE;
      endcase
    end
  end

  // fetch opens for a single instruction only while a step is outstanding
  assign cpu_step_grant  = (step_state == ODC_STEP_GRANT);
  assign cpu_fetch_stall = cpu_ctrl[CC_HALT] & (step_state == ODC_STEP_IDLE);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      breakpoint_event  <= 1'b0;
      illegal_trap      <= 1'b0;
      cpu_loop_on_break <= 1'b0;
    end else begin
      breakpoint_event  <= bp_taken;
      illegal_trap      <= bp_any & ~cpu_ctrl[CC_BPEN];
      cpu_loop_on_break <= bp_taken & ~cpu_ctrl[CC_BPHALT];
    end
  end

  // the break flag: a break in the same cycle as the clearing write still sets it
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      break_reached_flag <= 1'b0;
    end else if (break_instr_exec) begin
      break_reached_flag <= 1'b1;
    end else if (halt_written_zero) begin
      break_reached_flag <= 1'b0;
    end
  end

  // the clock gate only matters while the cpu sits in stop mode
  assign stop_mode_clock_gate = cpu_in_stop & ~cpu_ctrl[CC_STOPCLK];

  // ---------------- events and read-back ----------------
  always_comb begin
    ev_set              = '0;
    ev_set[EV_BREAK]    = bp_taken;
    ev_set[EV_TRAP]     = bp_any & ~cpu_ctrl[CC_BPEN];
    ev_set[EV_AUTOBAUD] = link_ctrl[LC_SEARCH] & autobaud_done;
    ev_set[EV_SERR]     = rx_serial_error;
  end

  odc_event_irq #(
    .W (EV_W)
  ) u_irq (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ev_set   (ev_set),
    .clr_wr   (regs.wr & (regs.reg_num == ODC_RN_EVCL)),
    .en_wr    (regs.wr & (regs.reg_num == ODC_RN_EVEN)),
    .wdata    (regs.wdata[EV_W-1:0]),
    .status   (ev_status),
    .enable   (ev_enable),
    .irq      (irq)
  );

  always_comb begin
    regs.rdata = 8'h00;
    unique case (regs.reg_num)
      ODC_RN_LINK:  regs.rdata = link_ctrl;
      ODC_RN_CPU:   regs.rdata = cpu_ctrl;
      ODC_RN_EVST:  regs.rdata[EV_W-1:0] = ev_status;
      ODC_RN_EVEN:  regs.rdata[EV_W-1:0] = ev_enable;
      ODC_RN_EVCL:  regs.rdata = 8'h00;
      ODC_RN_DSTAT: begin
        regs.rdata[DS_HALT] = cpu_ctrl[CC_HALT];
        regs.rdata[DS_BREAK] = break_reached_flag;
        regs.rdata[DS_STOP] = cpu_in_stop;
        regs.rdata[DS_STEP] = (step_state != ODC_STEP_IDLE);
      end
      default: regs.rdata = 8'h00;
    endcase
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_lock_holds_reg: assert property (
    link_ctrl[LC_LOCK] && !rx_serial_error && !autobaud_done |=> $stable(link_ctrl))
    else $error("locked link control changed");

  a_option_forces_lock: assert property (
    debug_uart_option |=> link_ctrl[LC_LOCK])
    else $error("lock not forced by option");

  a_cmd_routing: assert property (
    rx_byte_valid && link_ctrl[LC_DBGEN] |=> cmd_byte_valid && !uart_byte_valid)
    else $error("debug byte not routed to command");

  a_dbgen_locked: assert property (
    link_ctrl[LC_LOCK] |=> link_ctrl[LC_DBGEN] == $past(link_ctrl[LC_DBGEN]))
    else $error("debug enable changed while locked");

  a_uart_gated: assert property (
    link_ctrl[LC_DBGEN] |-> !serial_port_on)
    else $error("serial port on in debug mode");

  a_search_clears: assert property (
    link_ctrl[LC_SEARCH] && autobaud_done && !(link_ctrl[LC_DBGEN] && rx_serial_error)
    |=> !autobaud_search && baud_reload == $past(autobaud_count))
    else $error("search did not load and clear");

  a_error_search: assert property (
    link_ctrl[LC_DBGEN] && rx_serial_error |=> autobaud_search)
    else $error("serial error did not set search");

  a_search_wr_block: assert property (
    link_ctrl[LC_DBGEN] && !rx_serial_error && !autobaud_done
    |=> link_ctrl[LC_CHSEL:LC_SEARCH] == $past(link_ctrl[LC_CHSEL:LC_SEARCH]))
    else $error("search fields written in debug mode");

  a_bp_halts: assert property (
    bp_taken && cpu_ctrl[CC_BPHALT] |=> cpu_ctrl[CC_HALT] && breakpoint_event)
    else $error("breakpoint did not halt");

  a_trap_select: assert property (
    bp_any && !cpu_ctrl[CC_BPEN] |=> illegal_trap && !breakpoint_event)
    else $error("trap not raised with breakpoints off");

  a_single_step: assert property (
    cpu_step_grant |=> !cpu_step_grant ##0 (!cpu_step_grant)[*1])
    else $error("step grant longer than one cycle");

  a_step_clears: assert property (
    step_state == ODC_STEP_WAIT && instr_retired |=> !cpu_ctrl[CC_STEP] ##1 !cpu_step_grant)
    else $error("step bit not cleared after instruction");

  a_break_flag: assert property (
    break_instr_exec |=> break_reached_flag)
    else $error("break flag not set");

  a_stall_needs_halt: assert property (
    !cpu_ctrl[CC_HALT] |-> !cpu_fetch_stall)
    else $error("fetch stalled while not halted");

  a_stop_gate_run: assert property (
    cpu_in_stop |-> stop_mode_clock_gate != cpu_ctrl[CC_STOPCLK])
    else $error("stop mode clock gate ignores control bit");

  a_stop_gate_idle: assert property (
    !cpu_in_stop |-> !stop_mode_clock_gate)
    else $error("clock gated outside stop mode");

  a_flag_clears: assert property (
    halt_written_zero && !break_instr_exec |=> !break_reached_flag)
    else $error("break flag not cleared by unhalt write");

  a_step_refused: assert property (
    !cpu_ctrl[CC_HALT] && !cpu_ctrl[CC_STEP] |=> !cpu_ctrl[CC_STEP])
    else $error("step armed while not halted");
endmodule // odc_top

// ### verification/odc_host_model.sv
// partner model: debug host side of the serial link, delivering bytes, line errors and baud results
`timescale 1ns/10ps
module odc_host_model #(
  parameter int BAUD_W = 16
) (
  input  wire logic              core_clk,
  output logic                   rx_byte_valid,
  output logic      [7:0]        rx_byte,
  output logic                   rx_serial_error,
  output logic                   autobaud_done,
  output logic      [BAUD_W-1:0] autobaud_count
);
  initial begin
    rx_byte_valid   = 1'b0;
    rx_byte         = 8'h00;
    rx_serial_error = 1'b0;
    autobaud_done   = 1'b0;
    autobaud_count  = '0;
  end

  // after its strobe the data shows the inverse, so a late capture reads garbage
  task automatic send_byte(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    rx_byte_valid <= 1'b1;
    rx_byte       <= b;
    @(posedge core_clk);
    rx_byte_valid <= 1'b0;
    rx_byte       <= ~b;
  endtask

  task automatic line_error();
    @(posedge core_clk);
    rx_serial_error <= 1'b1;
    @(posedge core_clk);
    rx_serial_error <= 1'b0;
  endtask

  // gap lets the host answer slowly, as a real measurement would
  task automatic baud_result(input logic [BAUD_W-1:0] c, input int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    autobaud_done  <= 1'b1;
    autobaud_count <= c;
    @(posedge core_clk);
    autobaud_done  <= 1'b0;
    autobaud_count <= ~c;
  endtask
endmodule // odc_host_model

// ### verification/test_on_chip_debug_control.sv
// testbench: register and event checks of the on-chip debug control block
`timescale 1ns/10ps
module test_on_chip_debug_control;
  import odc_pkg::*;
  localparam int BW = 16;
  logic          core_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, debug_uart_option, cpu_in_stop;
  logic [3:0]    wb_sel_i;
  logic [31:0]   wb_adr_i, wb_dat_i, wb_dat_o, rd, n, fails, checks_done;
  logic          rx_byte_valid, rx_serial_error, autobaud_done, debug_mode_enable, command_crc_enable;
  logic          serial_port_on, autobaud_char_select, autobaud_search, cmd_byte_valid, uart_byte_valid;
  logic          cpu_fetch_stall, cpu_step_grant, cpu_loop_on_break, breakpoint_event, illegal_trap;
  logic          stop_mode_clock_gate, break_reached_flag, irq;
  logic [7:0]    rx_byte, autobaud_char, rx_data;
  logic [BW-1:0] autobaud_count, baud_reload;
  logic [2:0]    cpu_ev;

  odc_top #(.BAUD_W(BW)) u_odc_top (
    .core_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .debug_uart_option, .rx_byte_valid, .rx_byte, .rx_serial_error, .autobaud_done, .autobaud_count,
    .break_instr_exec(cpu_ev[0]), .hw_breakpoint_hit(cpu_ev[1]), .cpu_in_stop, .instr_retired(cpu_ev[2]),
    .debug_mode_enable, .command_crc_enable, .serial_port_on, .autobaud_char_select, .autobaud_char,
    .autobaud_search, .baud_reload, .cmd_byte_valid, .uart_byte_valid, .rx_data, .cpu_fetch_stall,
    .cpu_step_grant, .cpu_loop_on_break, .breakpoint_event, .illegal_trap, .stop_mode_clock_gate,
    .break_reached_flag, .irq
  );

  odc_host_model #(.BAUD_W(BW)) u_odc_host_model (
    .core_clk, .rx_byte_valid, .rx_byte, .rx_serial_error, .autobaud_done, .autobaud_count
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic finish_test();
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; read data is taken at the ack edge only
  task automatic wb(input logic we, input logic [29:0] idx, input logic [7:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'h1;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) @(posedge core_clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [29:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d);
  endtask

  task automatic rc(input logic [29:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask

  // cpu side pulses: bit0 break instruction, bit1 hardware hit, bit2 retire
  task automatic fire(input logic [2:0] v);
    @(posedge core_clk);
    cpu_ev <= v;
    @(posedge core_clk);
    cpu_ev <= 3'b000;
    @(negedge core_clk);
  endtask

  initial begin
    repeat (3000) @(posedge core_clk);
    fails = fails + 1;
    finish_test();
  end

  initial begin
    rstn = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
    wb_sel_i = 4'h0;
    wb_adr_i = 32'h00000000;
    wb_dat_i = 32'h00000000;
    debug_uart_option = 1'b1;
    cpu_in_stop = 1'b0;
    cpu_ev = 3'b000;
    fails = 32'h0;
    checks_done = 32'h0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk({debug_mode_enable, command_crc_enable, serial_port_on, autobaud_search, autobaud_char}, 12'hd80);
    rc(LINK_CTRL_IDX, 8'hc9);
    rc(CPU_CTRL_IDX, 8'h00);
    debug_uart_option <= 1'b0;
    wr(LINK_CTRL_IDX, 8'h06);
    rc(LINK_CTRL_IDX, 8'hc9);
    chk({serial_port_on, autobaud_char_select, command_crc_enable}, 3'b001);
    u_odc_host_model.send_byte(8'h3c, 0);
    @(negedge core_clk);
    chk({cmd_byte_valid, uart_byte_valid, rx_data}, 10'h23c);
    u_odc_host_model.baud_result(16'h1234, 3);
    @(negedge core_clk);
    chk({autobaud_search, baud_reload}, 17'h01234);
    rc(LINK_CTRL_IDX, 8'hc8);
    u_odc_host_model.baud_result(16'h0777, 0);
    @(negedge core_clk);
    chk(baud_reload, 16'h1234);
    u_odc_host_model.line_error();
    @(negedge core_clk);
    chk(autobaud_search, 1'b1);
    rc(LINK_CTRL_IDX, 8'hc9);
    wr(CPU_CTRL_IDX, 8'h80);
    @(negedge core_clk);
    chk(cpu_fetch_stall, 1'b1);
    wr(CPU_CTRL_IDX, 8'h81);
    n = 32'h0;
    repeat (4) begin
      @(negedge core_clk);
      n = n + cpu_step_grant;
    end
    chk({n[30:0], cpu_fetch_stall}, 32'h2);
    rc(RUN_STAT_IDX, 8'h81);
    fire(3'b100);
    @(negedge core_clk);
    chk(cpu_fetch_stall, 1'b1);
    rc(CPU_CTRL_IDX, 8'h80);
    wr(CPU_CTRL_IDX, 8'h00);
    @(negedge core_clk);
    chk(cpu_fetch_stall, 1'b0);
    fire(3'b001);
    chk({breakpoint_event, cpu_loop_on_break, illegal_trap, break_reached_flag}, 4'b0011);
    fire(3'b010);
    chk({breakpoint_event, cpu_loop_on_break, illegal_trap}, 3'b001);
    wr(CPU_CTRL_IDX, 8'h00);
    rc(RUN_STAT_IDX, 8'h00);
    wr(CPU_CTRL_IDX, 8'h20);
    fire(3'b010);
    chk({breakpoint_event, cpu_loop_on_break, illegal_trap, cpu_fetch_stall}, 4'b1100);
    rc(CPU_CTRL_IDX, 8'h20);
    wr(CPU_CTRL_IDX, 8'h60);
    fire(3'b001);
    chk({breakpoint_event, cpu_loop_on_break, break_reached_flag, cpu_fetch_stall}, 4'b1011);
    rc(CPU_CTRL_IDX, 8'he0);
    wr(CPU_CTRL_IDX, 8'h60);
    @(negedge core_clk);
    chk({break_reached_flag, cpu_fetch_stall}, 2'b00);
    @(posedge core_clk);
    cpu_in_stop <= 1'b1;
    @(negedge core_clk);
    chk(stop_mode_clock_gate, 1'b1);
    wr(CPU_CTRL_IDX, 8'h10);
    @(negedge core_clk);
    chk(stop_mode_clock_gate, 1'b0);
    rc(RUN_STAT_IDX, 8'h10);
    // every event source has fired by now, but nothing is enabled yet
    rc(EV_STAT_IDX, 8'h0f);
    chk(irq, 1'b0);
    wr(EV_EN_IDX, 8'h08);
    @(negedge core_clk);
    chk(irq, 1'b1);
    wr(EV_CLR_IDX, 8'h0b);
    rc(EV_STAT_IDX, 8'h04);
    chk(irq, 1'b0);
    rc(EV_CLR_IDX, 8'h00);
    rc(EV_EN_IDX, 8'h08);
    u_odc_host_model.line_error();
    @(negedge core_clk);
    chk(irq, 1'b1);
    wr(EV_STAT_IDX, 8'h00);
    rc(EV_STAT_IDX, 8'h0c);
    wr(30'h0ffe087, 8'hff);
    rc(30'h0ffe087, 8'h00);
    finish_test();
  end
endmodule // test_on_chip_debug_control
